/* File: common/sxcap_pkg.sv */
package sxcap_pkg;

    localparam int ADDR_W = 12;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] OFF_ACS_HDR   = 12'h220;
    localparam logic [11:0] OFF_ACS_CAP   = 12'h224;
    localparam logic [11:0] OFF_EGR_VEC   = 12'h228;
    localparam logic [11:0] OFF_LTR_HDR   = 12'h230;
    localparam logic [11:0] OFF_MAX_LAT   = 12'h234;
    localparam logic [11:0] OFF_L1SS_HDR  = 12'h240;

    // ---------------------------------------------------------------
    // capability header contents
    // ---------------------------------------------------------------
    localparam logic [15:0] ACS_CAP_ID    = 16'h000D;
    localparam logic [15:0] LTR_CAP_ID    = 16'h0018;
    localparam logic [15:0] L1SS_CAP_ID   = 16'h001E;
    localparam logic [3:0]  CAP_VERSION   = 4'h1;
    localparam logic [11:0] NEXT_L1SS     = 12'h240;
    localparam logic [11:0] NEXT_UP_PTM   = 12'h260;
    localparam logic [11:0] NEXT_DN_DPC   = 12'h250;

    // ---------------------------------------------------------------
    // field layout and reset values
    // ---------------------------------------------------------------
    localparam int          ACS_FEAT_N    = 7;
    localparam int          ACS_EN_LSB    = 16;
    localparam int          ACS_EGR_EN    = 5;
    localparam logic [6:0]  ACS_SUPPORT   = 7'h7F;
    localparam logic [7:0]  EGR_VEC_SIZE  = 8'h08;
    localparam int          EGR_N         = 8;
    localparam logic [6:0]  ACS_EN_RST    = 7'h00;
    localparam logic [7:0]  EGR_VEC_RST   = 8'h00;
    localparam logic [9:0]  LAT_VAL_RST   = 10'h000;
    localparam logic [2:0]  LAT_SCL_RST   = 3'h0;
    localparam int          SNP_VAL_LSB   = 0;
    localparam int          SNP_SCL_LSB   = 10;
    localparam int          NSN_VAL_LSB   = 16;
    localparam int          NSN_SCL_LSB   = 26;

    // ---------------------------------------------------------------
    // bus answers
    // ---------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    function automatic logic [31:0] cap_header(input logic [15:0] id,
                                               input logic [11:0] next);
        cap_header = {next, CAP_VERSION, id};
    endfunction : cap_header

    // merge a write into a stored word, lane by lane
    function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        apply_strb = res;
    endfunction : apply_strb

endpackage : sxcap_pkg

/* File: hw/sxcap_egress_filter.sv */
`timescale 1ns/1ps
module sxcap_egress_filter (
    input  wire logic       clk,            // core clock
    input  wire logic       rstn,           // synchronous reset, active low
    input  wire logic       egress_en,      // egress control enable
    input  wire logic [7:0] egress_vec,     // per-port block bits
    input  wire logic       peer_valid,     // peer request to check
    input  wire logic [2:0] peer_port,      // target port of the request
    output logic            chk_valid,      // verdict valid, one cycle
    output logic            chk_blocked     // request must be blocked or redirected
);
    logic valid_reg;
    logic blocked_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            valid_reg   <= 1'b0;
            blocked_reg <= 1'b0;
        end else begin
            valid_reg   <= peer_valid;
            blocked_reg <= peer_valid & egress_en & egress_vec[peer_port];
        end
    end

    assign chk_valid   = valid_reg;
    assign chk_blocked = blocked_reg;
endmodule : sxcap_egress_filter

/* File: hw/sxcap_regs.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sxcap_regs (
    input  wire logic        clk,              // core clock, 100 MHz
    input  wire logic        rstn,             // synchronous reset, active low
    input  wire logic        upstream_strap,   // pin: high for the upstream port
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,     // write address
    input  wire logic        s_axi_awvalid,    // write address valid
    output logic             s_axi_awready,    // write address ready
    input  wire logic [31:0] s_axi_wdata,      // write data
    input  wire logic [3:0]  s_axi_wstrb,      // write byte strobes
    input  wire logic        s_axi_wvalid,     // write data valid
    output logic             s_axi_wready,     // write data ready
    output logic [1:0]       s_axi_bresp,      // write response
    output logic             s_axi_bvalid,     // write response valid
    input  wire logic        s_axi_bready,     // write response ready
    input  wire logic [11:0] s_axi_araddr,     // read address
    input  wire logic        s_axi_arvalid,    // read address valid
    output logic             s_axi_arready,    // read address ready
    output logic [31:0]      s_axi_rdata,      // read data
    output logic [1:0]       s_axi_rresp,      // read response
    output logic             s_axi_rvalid,     // read data valid
    input  wire logic        s_axi_rready,     // read data ready
    // block controls
    output logic [6:0]       acs_enable,       // ACS feature enables
    output logic [7:0]       egress_vector,    // egress control vector
    output logic [9:0]       snoop_lat_value,  // max snoop latency value
    output logic [2:0]       snoop_lat_scale,  // max snoop latency scale
    output logic [9:0]       nosnoop_lat_value,// max no-snoop latency value
    output logic [2:0]       nosnoop_lat_scale,// max no-snoop latency scale
    output logic             is_upstream,      // synchronised port role
    // peer request check
    input  wire logic        peer_valid,       // peer request to check
    input  wire logic [2:0]  peer_port,        // its target port
    output logic             peer_chk_valid,   // verdict valid
    output logic             peer_chk_blocked  // verdict: block or redirect
);

    // ---------------------------------------------------------------
    // port role
    // ---------------------------------------------------------------
    // role is a board strap; it is expected to be static while running
    logic role_up;

    sxcap_sync u_role_sync (
        .clk   (clk),
        .rstn  (rstn),
        .d_in  (upstream_strap),
        .q_out (role_up)
    );

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [6:0]  acs_en_reg;
    logic [7:0]  egr_vec_reg;
    logic [9:0]  snp_val_reg;
    logic [2:0]  snp_scl_reg;
    logic [9:0]  nsn_val_reg;
    logic [2:0]  nsn_scl_reg;

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] wr_data_reg;
    logic [3:0]  wr_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_fire;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_held_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            wr_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            w_held_reg  <= 1'b0;
            wr_data_reg <= 32'h0000_0000;
            wr_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg  <= 1'b1;
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    function automatic logic word_hit(input logic [11:0] a, input logic [11:0] off);
        word_hit = (a[11:2] == off[11:2]);
    endfunction : word_hit

    function automatic logic mapped(input logic [11:0] a);
        mapped = word_hit(a, sxcap_pkg::OFF_ACS_HDR) || word_hit(a, sxcap_pkg::OFF_ACS_CAP)
              || word_hit(a, sxcap_pkg::OFF_EGR_VEC) || word_hit(a, sxcap_pkg::OFF_LTR_HDR)
              || word_hit(a, sxcap_pkg::OFF_MAX_LAT) || word_hit(a, sxcap_pkg::OFF_L1SS_HDR);
    endfunction : mapped

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= sxcap_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(wr_addr_reg) ? sxcap_pkg::RESP_OKAY : sxcap_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ---------------------------------------------------------------
    // register updates
    // ---------------------------------------------------------------
    // only writable fields are stored; headers, read-only and reserved bits
    // have no flops, so writes to them are dropped by construction
    logic [31:0] acs_merge;
    logic [31:0] egr_merge;
    logic [31:0] lat_merge;

    assign acs_merge = sxcap_pkg::apply_strb(32'h0000_0000, wr_data_reg, wr_strb_reg);
    assign egr_merge = sxcap_pkg::apply_strb({24'h00_0000, egr_vec_reg}, wr_data_reg,
                                             wr_strb_reg);
    assign lat_merge = sxcap_pkg::apply_strb({3'h0, nsn_scl_reg, nsn_val_reg,
                                              3'h0, snp_scl_reg, snp_val_reg},
                                             wr_data_reg, wr_strb_reg);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            acs_en_reg <= sxcap_pkg::ACS_EN_RST;
        end else if (wr_fire && !role_up && word_hit(wr_addr_reg, sxcap_pkg::OFF_ACS_CAP)
                     && wr_strb_reg[2]) begin
            acs_en_reg <= acs_merge[sxcap_pkg::ACS_EN_LSB +: sxcap_pkg::ACS_FEAT_N];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            egr_vec_reg <= sxcap_pkg::EGR_VEC_RST;
        end else if (wr_fire && !role_up && word_hit(wr_addr_reg, sxcap_pkg::OFF_EGR_VEC)) begin
            egr_vec_reg <= egr_merge[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            snp_val_reg <= sxcap_pkg::LAT_VAL_RST;
            snp_scl_reg <= sxcap_pkg::LAT_SCL_RST;
            nsn_val_reg <= sxcap_pkg::LAT_VAL_RST;
            nsn_scl_reg <= sxcap_pkg::LAT_SCL_RST;
        end else if (wr_fire && role_up && word_hit(wr_addr_reg, sxcap_pkg::OFF_MAX_LAT)) begin
            snp_val_reg <= lat_merge[sxcap_pkg::SNP_VAL_LSB +: 10];
            snp_scl_reg <= lat_merge[sxcap_pkg::SNP_SCL_LSB +: 3];
            nsn_val_reg <= lat_merge[sxcap_pkg::NSN_VAL_LSB +: 10];
            nsn_scl_reg <= lat_merge[sxcap_pkg::NSN_SCL_LSB +: 3];
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // registers absent for this role read as zero with OKAY, like empty config space
    function automatic logic [31:0] read_word(input logic [11:0] a, input logic up);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (word_hit(a, sxcap_pkg::OFF_ACS_HDR) && !up) begin
            v = sxcap_pkg::cap_header(sxcap_pkg::ACS_CAP_ID, sxcap_pkg::NEXT_L1SS);
        end else if (word_hit(a, sxcap_pkg::OFF_ACS_CAP) && !up) begin
            v = {9'h000, acs_en_reg, sxcap_pkg::EGR_VEC_SIZE, 1'b0,
                 sxcap_pkg::ACS_SUPPORT};
        end else if (word_hit(a, sxcap_pkg::OFF_EGR_VEC) && !up) begin
            v = {24'h00_0000, egr_vec_reg};
        end else if (word_hit(a, sxcap_pkg::OFF_LTR_HDR) && up) begin
            v = sxcap_pkg::cap_header(sxcap_pkg::LTR_CAP_ID, sxcap_pkg::NEXT_L1SS);
        end else if (word_hit(a, sxcap_pkg::OFF_MAX_LAT) && up) begin
            v = {3'h0, nsn_scl_reg, nsn_val_reg, 3'h0, snp_scl_reg, snp_val_reg};
        end else if (word_hit(a, sxcap_pkg::OFF_L1SS_HDR)) begin
            v = sxcap_pkg::cap_header(sxcap_pkg::L1SS_CAP_ID,
                    up ? sxcap_pkg::NEXT_UP_PTM : sxcap_pkg::NEXT_DN_DPC);
        end
        read_word = v;
    endfunction : read_word

    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= sxcap_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= read_word(s_axi_araddr, role_up);
            rresp_reg  <= mapped(s_axi_araddr) ? sxcap_pkg::RESP_OKAY : sxcap_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // ---------------------------------------------------------------
    // block outputs
    // ---------------------------------------------------------------
    assign acs_enable        = acs_en_reg;
    assign egress_vector     = egr_vec_reg;
    assign snoop_lat_value   = snp_val_reg;
    assign snoop_lat_scale   = snp_scl_reg;
    assign nosnoop_lat_value = nsn_val_reg;
    assign nosnoop_lat_scale = nsn_scl_reg;
    assign is_upstream       = role_up;

    sxcap_egress_filter u_egress (
        .clk         (clk),
        .rstn        (rstn),
        .egress_en   (acs_en_reg[sxcap_pkg::ACS_EGR_EN]),
        .egress_vec  (egr_vec_reg),
        .peer_valid  (peer_valid),
        .peer_port   (peer_port),
        .chk_valid   (peer_chk_valid),
        .chk_blocked (peer_chk_blocked)
    );

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic rd_go;
    logic [11:0] ra;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign ra    = s_axi_araddr;

    AST_ACS_HDR: assert property (rd_go && ra == 12'h220 && !role_up
        |=> s_axi_rvalid && s_axi_rdata == 32'h2401_000D)
        else $error("acs header wrong");
    AST_ACS_ABSENT_UP: assert property (rd_go && ra == 12'h224 && role_up
        |=> s_axi_rdata == 32'h0000_0000)
        else $error("acs word visible on upstream");
    AST_ACS_SUPPORT: assert property (rd_go && ra == 12'h224 && !role_up
        |=> s_axi_rdata[6:0] == 7'h7F)
        else $error("acs support bits wrong");
    AST_ACS_VSIZE: assert property (rd_go && ra == 12'h224 && !role_up
        |=> s_axi_rdata[15:8] == 8'h08)
        else $error("egress vector size wrong");
    AST_ACS_EN_WR: assert property (wr_fire && !role_up && wr_addr_reg == 12'h224
        && wr_strb_reg[2] |=> acs_enable == $past(wr_data_reg[22:16]))
        else $error("acs enable not written");
    AST_ACS_RSVD: assert property (rd_go && ra == 12'h224
        |=> s_axi_rdata[7] == 1'b0 && s_axi_rdata[31:23] == 9'h000)
        else $error("acs reserved bits nonzero");
    AST_EGR_WR: assert property (wr_fire && !role_up && wr_addr_reg == 12'h228
        && wr_strb_reg[0] |=> egress_vector == $past(wr_data_reg[7:0]))
        else $error("egress vector not written");
    AST_LTR_HDR: assert property (rd_go && ra == 12'h230 && role_up
        |=> s_axi_rdata[19:0] == 20'h1_0018)
        else $error("ltr header wrong");
    AST_LTR_NEXT: assert property (rd_go && ra == 12'h230 && role_up
        |=> s_axi_rdata[31:20] == 12'h240)
        else $error("ltr next pointer wrong");
    AST_SNOOP_WR: assert property (wr_fire && role_up && wr_addr_reg == 12'h234
        && wr_strb_reg[1:0] == 2'b11 |=> snoop_lat_value == $past(wr_data_reg[9:0])
        && snoop_lat_scale == $past(wr_data_reg[12:10]))
        else $error("snoop latency not written");
    AST_NOSNOOP_WR: assert property (wr_fire && role_up && wr_addr_reg == 12'h234
        && wr_strb_reg[3:2] == 2'b11 |=> nosnoop_lat_value == $past(wr_data_reg[25:16])
        && nosnoop_lat_scale == $past(wr_data_reg[28:26]))
        else $error("no-snoop latency not written");
    AST_L1SS_HDR: assert property (rd_go && ra == 12'h240
        |=> s_axi_rdata[19:0] == 20'h1_001E)
        else $error("l1 substates header wrong");
    AST_L1SS_NEXT: assert property (rd_go && ra == 12'h240
        |=> s_axi_rdata[31:20] == (role_up ? 12'h260 : 12'h250))
        else $error("l1 substates next pointer wrong");
    AST_EGR_GATE: assert property (peer_valid && !acs_en_reg[5]
        |=> peer_chk_valid && !peer_chk_blocked)
        else $error("egress blocked while disabled");
    AST_RO_WRITE: assert property (wr_fire && wr_addr_reg == 12'h240
        |=> $stable(acs_enable) && $stable(egress_vector) && $stable(snoop_lat_value))
        else $error("read-only write changed state");
    AST_BRESP_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");

    COV_ACS_WRITE: cover property (wr_fire && wr_addr_reg == 12'h224 && !role_up);
    COV_LAT_WRITE: cover property (wr_fire && wr_addr_reg == 12'h234 && role_up);
    COV_L1SS_READ: cover property (rd_go && ra == 12'h240);
    COV_PEER_BLOCK: cover property (peer_chk_blocked);

endmodule : sxcap_regs

/* File: hw/sxcap_sync.sv */
`timescale 1ns/1ps
module sxcap_sync (
    input  wire logic clk,     // core clock
    input  wire logic rstn,    // synchronous reset, active low
    input  wire logic d_in,    // asynchronous level
    output logic      q_out    // level in the clk domain
);
    logic meta_reg;
    logic sync_reg;

    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule : sxcap_sync

/* File: verification/sxcap_tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        strap = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        pv = 1'b0;
    logic [2:0]  pp = 3'h0;
    logic        awready, wready, bvalid, arready, rvalid, is_up, cv, cb;
    logic [1:0]  bresp, rresp;
    logic [6:0]  acs_en;
    logic [7:0]  egv;
    logic [9:0]  slv, nslv;
    logic [2:0]  ssc, nssc;
    int          error_cnt = 0;
    int          n_tests = 0;

    sxcap_regs DUT (.clk(clk), .rstn(rstn), .upstream_strap(strap),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .acs_enable(acs_en), .egress_vector(egv), .snoop_lat_value(slv),
        .snoop_lat_scale(ssc), .nosnoop_lat_value(nslv), .nosnoop_lat_scale(nssc),
        .is_upstream(is_up), .peer_valid(pv), .peer_port(pp),
        .peer_chk_valid(cv), .peer_chk_blocked(cb));

    initial begin
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // bus, peer-check and result tasks
    // ---------------------------------------------------------------
    task test_done;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // readies are sampled at the falling edge, where they already equal the next rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic       aw, w, b;
        logic [1:0] resp;
        b = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; !b; n++) begin
            if (n == 50) begin
                error_cnt++;
                test_done();
            end
            @(negedge clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid & bready;
            resp = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check({30'h0000_0000, resp}, {30'h0000_0000, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        ar, r;
        logic [31:0] d;
        logic [1:0]  resp;
        r = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; !r; n++) begin
            if (n == 50) begin
                error_cnt++;
                test_done();
            end
            @(negedge clk);
            ar = arvalid & arready;
            r = rvalid & rready;
            d = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        check(d, ed);
        check({30'h0000_0000, resp}, {30'h0000_0000, er});
    endtask : rd

    task automatic peer(input logic [2:0] p, input logic eb);
        @(posedge clk);
        pv <= 1'b1;
        pp <= p;
        @(posedge clk);
        pv <= 1'b0;
        @(negedge clk);
        check({31'h0000_0000, cv}, 32'h0000_0001);
        check({31'h0000_0000, cb}, {31'h0000_0000, eb});
    endtask : peer

    // ---------------------------------------------------------------
    // sequence: downstream role first, then upstream after a new reset
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0000_0000, is_up}, 32'h0000_0000);
        rd(12'h220, 32'h2401_000D, 2'b00);
        rd(12'h224, 32'h0000_087F, 2'b00);
        rd(12'h228, 32'h0000_0000, 2'b00);
        rd(12'h240, 32'h2501_001E, 2'b00);
        rd(12'h230, 32'h0000_0000, 2'b00);
        wr(12'h224, 32'hFFFF_FFFF, 4'hF, 2'b00);
        rd(12'h224, 32'h007F_087F, 2'b00);
        check({25'h000_0000, acs_en}, 32'h0000_007F);
        wr(12'h228, 32'h0000_0008, 4'hF, 2'b00);
        rd(12'h228, 32'h0000_0008, 2'b00);
        check({24'h00_0000, egv}, 32'h0000_0008);
        peer(3'h3, 1'b1);
        peer(3'h2, 1'b0);
        wr(12'h224, 32'h0000_0000, 4'hF, 2'b00);
        peer(3'h3, 1'b0);
        wr(12'h220, 32'hFFFF_FFFF, 4'hF, 2'b00);
        rd(12'h220, 32'h2401_000D, 2'b00);
        wr(12'h240, 32'hFFFF_FFFF, 4'hF, 2'b00);
        rd(12'h240, 32'h2501_001E, 2'b00);
        // enables live in byte lane 2 only; a write without that lane leaves them alone
        wr(12'h224, 32'hFFFF_FFFF, 4'hB, 2'b00);
        check({25'h000_0000, acs_en}, 32'h0000_0000);
        wr(12'h2FC, 32'hFFFF_FFFF, 4'hF, 2'b10);
        rd(12'h2FC, 32'h0000_0000, 2'b10);
        wr(12'h234, 32'hFFFF_FFFF, 4'hF, 2'b00);
        rd(12'h234, 32'h0000_0000, 2'b00);
        // the strap is only sampled as static, so the role change goes through reset
        @(posedge clk);
        strap <= 1'b1;
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(12'h230, 32'h2401_0018, 2'b00);
        check({31'h0000_0000, is_up}, 32'h0000_0001);
        rd(12'h240, 32'h2601_001E, 2'b00);
        rd(12'h224, 32'h0000_0000, 2'b00);
        rd(12'h234, 32'h0000_0000, 2'b00);
        wr(12'h234, 32'hFFFF_0AAA, 4'hF, 2'b00);
        rd(12'h234, 32'h1FFF_0AAA, 2'b00);
        check({6'h00, nssc, nslv, ssc, slv}, {6'h00, 3'h7, 10'h3FF, 3'h2, 10'h2AA});
        wr(12'h234, 32'h0000_0000, 4'h1, 2'b00);
        rd(12'h234, 32'h1FFF_0A00, 2'b00);
        test_done();
    end
endmodule : tb
